/* File: logic/rfa_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module rfa_reg_bank (
  input  wire  logic                                 clk,
  input  wire  logic                                 rst,
  input  wire  rfa_pkg::rfa_req_s                    req,
  input  wire  logic [rfa_pkg::EVT_W-1:0]            hw_evt,
  input  wire  logic [rfa_pkg::STAT_W-1:0]           hw_stat,
  input  wire  logic [rfa_pkg::PEND_W-1:0]           hw_pend,
  input  wire  logic [rfa_pkg::HWRO_W-1:0]           hw_ro,
  output logic       [rfa_pkg::DATA_W-1:0]           rdata_q,
  output logic                                       rvalid_q,
  output logic       [rfa_pkg::CTRL_HI_W-1:0]        ctrl_hi,
  output logic       [rfa_pkg::CTRL_LO_W-1:0]        ctrl_lo,
  output logic       [rfa_pkg::STAT_W-1:0]           stat,
  output logic       [rfa_pkg::PEND_W-1:0]           pend,
  output logic       [rfa_pkg::DATA_W-1:0]           cmd_q,
  output logic                                       cmd_stb_q
);

  localparam int unsigned DW = rfa_pkg::DATA_W;
  localparam int unsigned IW = rfa_pkg::HWRO_W + rfa_pkg::PEND_W;

  // Per-register strobes from the index.
  wire sel_evt  = (req.idx == rfa_pkg::IDX_EVT);
  wire sel_ctrl = (req.idx == rfa_pkg::IDX_CTRL);
  wire sel_stat = (req.idx == rfa_pkg::IDX_STAT);
  wire sel_pclr = (req.idx == rfa_pkg::IDX_PCLR);
  wire sel_cmd  = (req.idx == rfa_pkg::IDX_CMD);
  wire sel_info = (req.idx == rfa_pkg::IDX_INFO);
  wire sel_none = !(sel_evt || sel_ctrl || sel_stat || sel_pclr || sel_cmd || sel_info);

  logic [rfa_pkg::EVT_W-1:0]     evt_q;
  logic [rfa_pkg::EVT_W-1:0]     evt_rv;
  logic [rfa_pkg::CTRL_HI_W-1:0] chi_rv;
  logic [rfa_pkg::CTRL_LO_W-1:0] clo_rv;
  logic [rfa_pkg::STAT_W-1:0]    stat_rv;
  logic [rfa_pkg::PEND_W-1:0]    pend_rv;
  logic [DW-1:0]                 cmd_rv;
  logic [IW-1:0]                 info_q;
  logic [IW-1:0]                 info_rv;

  // Clear-on-read event accumulator.
  rfa_field_cell #(.W(rfa_pkg::EVT_W), .ACC(rfa_pkg::RFA_ACC_RC)) u_evt (
    .clk(clk), .rst(rst), .rd(req.rd && sel_evt), .wr(1'b0),
    .wdata(req.wdata[rfa_pkg::EVT_W-1:0]), .hw_set(hw_evt), .hw_val(hw_evt),
    .val_q(evt_q), .rview(evt_rv));

  // Control register, upper field spans 31:15 whole.
  rfa_field_cell #(.W(rfa_pkg::CTRL_HI_W), .ACC(rfa_pkg::RFA_ACC_RW),
                   .RST_VAL(rfa_pkg::CTRL_HI_RST)) u_chi (
    .clk(clk), .rst(rst), .rd(req.rd && sel_ctrl), .wr(req.wr && sel_ctrl),
    .wdata(req.wdata[rfa_pkg::CTRL_HI_MSB:rfa_pkg::CTRL_HI_LSB]),
    .hw_set('0), .hw_val('0), .val_q(ctrl_hi), .rview(chi_rv));

  rfa_field_cell #(.W(rfa_pkg::CTRL_LO_W), .ACC(rfa_pkg::RFA_ACC_RW),
                   .RST_VAL(rfa_pkg::CTRL_LO_RST)) u_clo (
    .clk(clk), .rst(rst), .rd(req.rd && sel_ctrl), .wr(req.wr && sel_ctrl),
    .wdata(req.wdata[rfa_pkg::CTRL_LO_MSB:rfa_pkg::CTRL_LO_LSB]),
    .hw_set('0), .hw_val('0), .val_q(ctrl_lo), .rview(clo_rv));

  // Readable write-one-to-clear status.
  rfa_field_cell #(.W(rfa_pkg::STAT_W), .ACC(rfa_pkg::RFA_ACC_RW1C)) u_stat (
    .clk(clk), .rst(rst), .rd(req.rd && sel_stat), .wr(req.wr && sel_stat),
    .wdata(req.wdata[rfa_pkg::STAT_W-1:0]), .hw_set(hw_stat), .hw_val('0),
    .val_q(stat), .rview(stat_rv));

  // Pending bits cleared through a write-only clear register.
  rfa_field_cell #(.W(rfa_pkg::PEND_W), .ACC(rfa_pkg::RFA_ACC_W1C)) u_pend (
    .clk(clk), .rst(rst), .rd(req.rd && sel_pclr), .wr(req.wr && sel_pclr),
    .wdata(req.wdata[rfa_pkg::PEND_W-1:0]), .hw_set(hw_pend), .hw_val('0),
    .val_q(pend), .rview(pend_rv));

  // Write-only command word.
  rfa_field_cell #(.W(DW), .ACC(rfa_pkg::RFA_ACC_WO)) u_cmd (
    .clk(clk), .rst(rst), .rd(req.rd && sel_cmd), .wr(req.wr && sel_cmd),
    .wdata(req.wdata), .hw_set('0), .hw_val('0), .val_q(cmd_q), .rview(cmd_rv));

  // Read-only view of pending bits and a hardware input; writes are ignored.
  rfa_field_cell #(.W(IW), .ACC(rfa_pkg::RFA_ACC_RO)) u_info (
    .clk(clk), .rst(rst), .rd(req.rd && sel_info), .wr(req.wr && sel_info),
    .wdata(req.wdata[IW-1:0]), .hw_set('0), .hw_val({pend, hw_ro}),
    .val_q(info_q), .rview(info_rv));

  // Read data selection; reserved bits and unmapped indices give zero.
  wire [DW-1:0] ctrl_word = {chi_rv, {(rfa_pkg::CTRL_RSV_MSB - rfa_pkg::CTRL_RSV_LSB + 1){1'b0}},
                             clo_rv};
  wire [DW-1:0] rd_mux =
    sel_evt  ? {{(DW - rfa_pkg::EVT_W){1'b0}}, evt_rv}   :
    sel_ctrl ? ctrl_word                                  :
    sel_stat ? {{(DW - rfa_pkg::STAT_W){1'b0}}, stat_rv} :
    sel_pclr ? {{(DW - rfa_pkg::PEND_W){1'b0}}, pend_rv} :
    sel_cmd  ? cmd_rv                                     :
    sel_info ? {{(DW - IW){1'b0}}, info_rv}               :
               rfa_pkg::DATA_ZERO;

  // Read data and command strobe are registered.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q   <= rfa_pkg::DATA_ZERO;
      rvalid_q  <= 1'b0;
      cmd_stb_q <= 1'b0;
    end else begin
      rdata_q   <= req.rd ? rd_mux : rdata_q;
      rvalid_q  <= req.rd;
      cmd_stb_q <= req.wr && sel_cmd;
    end
  end

  // Named sequences for the read-then-clear behaviour.
  sequence s_evt_read;
    req.rd && sel_evt;
  endsequence

  sequence s_evt_after;
    rdata_q == {{(DW - rfa_pkg::EVT_W){1'b0}}, $past(evt_q)} && evt_q == $past(hw_evt);
  endsequence

  property p_rc_read;
    @(posedge clk) disable iff (rst) s_evt_read |=> s_evt_after;
  endproperty
  a_rc_read: assert property (p_rc_read) else $error("clear-on-read field wrong");

  // Status writes clear only the bits written as one.
  property p_rw1c;
    @(posedge clk) disable iff (rst)
      (req.wr && sel_stat) |=> ((stat & ~$past(hw_stat)) ==
        ($past(stat) & ~$past(req.wdata[rfa_pkg::STAT_W-1:0]) & ~$past(hw_stat)));
  endproperty
  a_rw1c: assert property (p_rw1c) else $error("status clear wrong");

  property p_w1c_clear;
    @(posedge clk) disable iff (rst)
      (req.wr && sel_pclr && !(|hw_pend)) |=>
        pend == ($past(pend) & ~$past(req.wdata[rfa_pkg::PEND_W-1:0]));
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("pending clear wrong");

  property p_w1c_read;
    @(posedge clk) disable iff (rst) (req.rd && sel_pclr) |=> rdata_q == rfa_pkg::DATA_ZERO;
  endproperty
  a_w1c_read: assert property (p_w1c_read) else $error("clear register read nonzero");

  property p_wo_cmd;
    @(posedge clk) disable iff (rst)
      (req.wr && sel_cmd) |=> (cmd_stb_q && cmd_q == $past(req.wdata)) ##1
        (!cmd_stb_q || $past(req.wr && sel_cmd));
  endproperty
  a_wo_cmd: assert property (p_wo_cmd) else $error("command write wrong");

  property p_reset_val;
    @(posedge clk) disable iff (rst)
      $past(rst) |-> ctrl_lo == rfa_pkg::CTRL_LO_RST && ctrl_hi == rfa_pkg::CTRL_HI_RST &&
                     stat == '0 && pend == '0;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset value wrong");

  property p_field_span;
    @(posedge clk) disable iff (rst)
      (req.wr && sel_ctrl) ##1 (req.rd && sel_ctrl && !req.wr) |=>
        rdata_q[rfa_pkg::CTRL_HI_MSB:rfa_pkg::CTRL_HI_LSB] ==
          $past(req.wdata[rfa_pkg::CTRL_HI_MSB:rfa_pkg::CTRL_HI_LSB], 2) &&
        rdata_q[rfa_pkg::CTRL_RSV_MSB:rfa_pkg::CTRL_RSV_LSB] == '0;
  endproperty
  a_field_span: assert property (p_field_span) else $error("field span wrong");

  property p_set_wins;
    @(posedge clk) disable iff (rst)
      (req.wr && sel_stat) |=> (stat & $past(hw_stat)) == $past(hw_stat);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost");

  // Between reads the event register only gathers new sets.
  sequence s_evt_idle;
    !(req.rd && sel_evt);
  endsequence

  sequence s_evt_gathered;
    evt_q == ($past(evt_q) | $past(hw_evt));
  endsequence

  property p_rc_keep;
    @(posedge clk) disable iff (rst) s_evt_idle |=> s_evt_gathered;
  endproperty
  a_rc_keep: assert property (p_rc_keep) else $error("event lost between reads");

  // Read data stands until the next read, and the answer flag pulses once.
  property p_rd_hold;
    @(posedge clk) disable iff (rst) !req.rd |=> !rvalid_q && $stable(rdata_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  // Control reads show zero in the reserved bits.
  property p_rsv_zero;
    @(posedge clk) disable iff (rst)
      (req.rd && sel_ctrl) |=> rdata_q[rfa_pkg::CTRL_RSV_MSB:rfa_pkg::CTRL_RSV_LSB] == '0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");

  // Indices past the map read as zero.
  property p_idx_zero;
    @(posedge clk) disable iff (rst) (req.rd && sel_none) |=> rdata_q == rfa_pkg::DATA_ZERO;
  endproperty
  a_idx_zero: assert property (p_idx_zero) else $error("unmapped read nonzero");

  // The read-only register tracks hardware whatever is written to it.
  property p_ro_track;
    @(posedge clk) disable iff (rst)
      (req.wr && sel_info) |=> info_q == {$past(pend), $past(hw_ro)};
  endproperty
  a_ro_track: assert property (p_ro_track) else $error("read-only field written");

  // The command word moves only on a command write.
  property p_cmd_keep;
    @(posedge clk) disable iff (rst) !(req.wr && sel_cmd) |=> $stable(cmd_q) && !cmd_stb_q;
  endproperty
  a_cmd_keep: assert property (p_cmd_keep) else $error("command changed");

  // Status bits without a write only gather new sets.
  property p_stat_keep;
    @(posedge clk) disable iff (rst)
      !(req.wr && sel_stat) |=> stat == ($past(stat) | $past(hw_stat));
  endproperty
  a_stat_keep: assert property (p_stat_keep) else $error("status moved");

endmodule : rfa_reg_bank
`default_nettype wire

/* File: logic/rfa_pkg.sv */
// How it works
// - A clear-on-read field returns its value, then clears after the read.
// - Readable write-one-to-clear: ones clear their bits, zeros leave bits alone.
// - Write-only clear: each one clears its target bit; reads mean nothing.
// - Write-only field acts on writes only; reads may return anything.
// - Every field takes its reset value after any reset.
// - A high:low field spans every bit from low to high inclusive.
package rfa_pkg;

  // Access behaviour of a field cell, one-hot coded.
  typedef enum logic [5:0] {
    RFA_ACC_RC   = 6'h01,
    RFA_ACC_RO   = 6'h02,
    RFA_ACC_RW   = 6'h04,
    RFA_ACC_RW1C = 6'h08,
    RFA_ACC_W1C  = 6'h10,
    RFA_ACC_WO   = 6'h20
  } rfa_acc_e;

  localparam int unsigned DATA_W  = 32;
  localparam int unsigned IDX_W   = 3;
  localparam int unsigned EVT_W   = 16;
  localparam int unsigned STAT_W  = 16;
  localparam int unsigned PEND_W  = 8;
  localparam int unsigned HWRO_W  = 8;

  // Register indices of the bank.
  localparam logic [IDX_W-1:0] IDX_EVT   = 3'h0;
  localparam logic [IDX_W-1:0] IDX_CTRL  = 3'h1;
  localparam logic [IDX_W-1:0] IDX_STAT  = 3'h2;
  localparam logic [IDX_W-1:0] IDX_PCLR  = 3'h3;
  localparam logic [IDX_W-1:0] IDX_CMD   = 3'h4;
  localparam logic [IDX_W-1:0] IDX_INFO  = 3'h5;

  // Control register layout: upper field 31:15, reserved 14:8, lower field 7:0.
  localparam int unsigned CTRL_HI_LSB = 15;
  localparam int unsigned CTRL_HI_MSB = 31;
  localparam int unsigned CTRL_HI_W   = CTRL_HI_MSB - CTRL_HI_LSB + 1;
  localparam int unsigned CTRL_LO_LSB = 0;
  localparam int unsigned CTRL_LO_MSB = 7;
  localparam int unsigned CTRL_LO_W   = CTRL_LO_MSB - CTRL_LO_LSB + 1;
  localparam int unsigned CTRL_RSV_LSB = 8;
  localparam int unsigned CTRL_RSV_MSB = 14;

  // Reset values.
  localparam logic [CTRL_HI_W-1:0] CTRL_HI_RST = 17'h00000;
  localparam logic [CTRL_LO_W-1:0] CTRL_LO_RST = 8'h01;
  localparam logic [DATA_W-1:0]    DATA_ZERO   = 32'h00000000;

  // One software access, taken in a single cycle.
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] wdata;
  } rfa_req_s;

  // Tells whether a field type returns its stored value on a read.
  function automatic logic rfa_readable(input rfa_acc_e acc);
    return (acc == RFA_ACC_RC) || (acc == RFA_ACC_RO) ||
           (acc == RFA_ACC_RW) || (acc == RFA_ACC_RW1C);
  endfunction : rfa_readable

endpackage : rfa_pkg

/* File: logic/rfa_field_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module rfa_field_cell #(
  parameter int unsigned        W       = 8,
  parameter rfa_pkg::rfa_acc_e  ACC     = rfa_pkg::RFA_ACC_RW,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  input  wire  logic         clk,
  input  wire  logic         rst,
  input  wire  logic         rd,
  input  wire  logic         wr,
  input  wire  logic [W-1:0] wdata,
  input  wire  logic [W-1:0] hw_set,
  input  wire  logic [W-1:0] hw_val,
  output logic       [W-1:0] val_q,
  output logic       [W-1:0] rview
);

  logic [W-1:0] val_d;
  wire          is_w1c  = (ACC == rfa_pkg::RFA_ACC_RW1C) || (ACC == rfa_pkg::RFA_ACC_W1C);
  wire          is_load = (ACC == rfa_pkg::RFA_ACC_RW) || (ACC == rfa_pkg::RFA_ACC_WO);
  wire          is_sets = is_w1c || (ACC == rfa_pkg::RFA_ACC_RC);
  wire  [W-1:0] clr_w1c = (is_w1c && wr) ? wdata : '0;
  wire  [W-1:0] clr_rc  = ((ACC == rfa_pkg::RFA_ACC_RC) && rd) ? '1 : '0;
  wire  [W-1:0] set_hw  = is_sets ? hw_set : '0;

  // Next value: loads for plain fields, tracking for read-only, else clear then set.
  always_comb begin
    if (ACC == rfa_pkg::RFA_ACC_RO) begin
      val_d = hw_val;
    end else if (is_load && wr) begin
      val_d = wdata;
    end else begin
      val_d = (val_q & ~(clr_w1c | clr_rc)) | set_hw;
    end
  end

  // State flops take the documented reset value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  // Write-only types read back as zero.
  assign rview = rfa_pkg::rfa_readable(ACC) ? val_q : '0;

endmodule : rfa_field_cell
`default_nettype wire

/* File: dv/rfa_reg_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rfa_reg_bank_tb;
  logic                                clk;
  logic                                rst;
  rfa_pkg::rfa_req_s                   req;
  logic [rfa_pkg::EVT_W-1:0]           hw_evt;
  logic [rfa_pkg::STAT_W-1:0]          hw_stat;
  logic [rfa_pkg::PEND_W-1:0]          hw_pend;
  logic [rfa_pkg::HWRO_W-1:0]          hw_ro;
  logic [rfa_pkg::DATA_W-1:0]          rdata_q;
  logic                                rvalid_q;
  logic [rfa_pkg::CTRL_HI_W-1:0]       ctrl_hi;
  logic [rfa_pkg::CTRL_LO_W-1:0]       ctrl_lo;
  logic [rfa_pkg::STAT_W-1:0]          stat;
  logic [rfa_pkg::PEND_W-1:0]          pend;
  logic [rfa_pkg::DATA_W-1:0]          cmd_q;
  logic                                cmd_stb_q;
  int                                  bad_count;
  int                                  comparisons;

  rfa_reg_bank dut (.clk(clk), .rst(rst), .req(req), .hw_evt(hw_evt), .hw_stat(hw_stat),
    .hw_pend(hw_pend), .hw_ro(hw_ro), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .ctrl_hi(ctrl_hi), .ctrl_lo(ctrl_lo), .stat(stat), .pend(pend), .cmd_q(cmd_q),
    .cmd_stb_q(cmd_stb_q));

  // Clock of 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // One access held for one edge; outputs are sampled once that edge has landed.
  task automatic acc(input logic rd, input logic wr, input logic [2:0] idx,
                     input logic [31:0] wd);
    @(posedge clk);
    req <= '{rd: rd, wr: wr, idx: idx, wdata: wd};
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b0, idx: 3'h0, wdata: 32'h00000000};
    #1;
  endtask : acc

  // Reset values of the ctrl, stat, pend and cmd outputs, with the control register read back through the bus.
  task automatic t_reset();
    #1;
    chk("ctrl_lo", {24'h000000, ctrl_lo}, 32'h00000001);
    chk("ctrl_hi", {15'h0000, ctrl_hi}, 32'h00000000);
    chk("stat", {16'h0000, stat}, 32'h00000000);
    chk("pend", {24'h000000, pend}, 32'h00000000);
    chk("cmd", cmd_q, 32'h00000000);
    acc(1'b1, 1'b0, rfa_pkg::IDX_CTRL, 32'h00000000);
    chk("ctrl_rd", rdata_q, 32'h00000001);
  endtask : t_reset

  // Clear-on-read returns the events once, then zero; a set during the read survives.
  task automatic t_rc();
    @(posedge clk);
    hw_evt <= 16'h00a5;
    @(posedge clk);
    hw_evt <= 16'h0000;
    acc(1'b1, 1'b0, rfa_pkg::IDX_EVT, 32'h00000000);
    chk("evt_rd", rdata_q, 32'h000000a5);
    chk("evt_rv", {31'h0, rvalid_q}, 32'h00000001);
    @(posedge clk);
    req    <= '{rd: 1'b1, wr: 1'b0, idx: rfa_pkg::IDX_EVT, wdata: 32'h00000000};
    hw_evt <= 16'h0100;
    @(posedge clk);
    req    <= '0;
    hw_evt <= 16'h0000;
    #1;
    chk("evt_rd2", rdata_q, 32'h00000000);
    acc(1'b1, 1'b0, rfa_pkg::IDX_EVT, 32'h00000000);
    chk("evt_rd3", rdata_q, 32'h00000100);
  endtask : t_rc

  // Read/write control with a 31:15 field and reserved bits reading zero.
  task automatic t_ctrl();
    acc(1'b0, 1'b1, rfa_pkg::IDX_CTRL, 32'hffffffff);
    chk("ctrl_hi", {15'h0000, ctrl_hi}, 32'h0001ffff);
    acc(1'b1, 1'b0, rfa_pkg::IDX_CTRL, 32'h00000000);
    chk("ctrl_rd", rdata_q, 32'hffff80ff);
    acc(1'b1, 1'b0, 3'h7, 32'h00000000);
    chk("idx7_rd", rdata_q, 32'h00000000);
    acc(1'b0, 1'b1, rfa_pkg::IDX_CTRL, 32'h00008042);
    chk("ctrl_hi", {15'h0000, ctrl_hi}, 32'h00000001);
    chk("ctrl_lo", {24'h000000, ctrl_lo}, 32'h00000042);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, idx: rfa_pkg::IDX_CTRL, wdata: 32'haaaa8055};
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, idx: rfa_pkg::IDX_CTRL, wdata: 32'h00000000};
    @(posedge clk);
    req <= '0;
    #1;
    chk("ctrl_b2b", rdata_q, 32'haaaa8055);
  endtask : t_ctrl

  // Write-one-to-clear status, including a set in the same cycle as its clear.
  task automatic t_w1c();
    @(posedge clk);
    hw_stat <= 16'h00ff;
    hw_pend <= 8'hff;
    @(posedge clk);
    hw_stat <= 16'h0000;
    hw_pend <= 8'h00;
    acc(1'b1, 1'b1, rfa_pkg::IDX_STAT, 32'h0000000f);
    chk("stat_rd", rdata_q, 32'h000000ff);
    chk("stat", {16'h0000, stat}, 32'h000000f0);
    @(posedge clk);
    req     <= '{rd: 1'b0, wr: 1'b1, idx: rfa_pkg::IDX_STAT, wdata: 32'h00000030};
    hw_stat <= 16'h0010;
    @(posedge clk);
    req     <= '0;
    hw_stat <= 16'h0000;
    #1;
    chk("stat_set", {16'h0000, stat}, 32'h000000d0);
    acc(1'b0, 1'b1, rfa_pkg::IDX_PCLR, 32'h0000000f);
    chk("pend", {24'h000000, pend}, 32'h000000f0);
    acc(1'b1, 1'b0, rfa_pkg::IDX_PCLR, 32'h00000000);
    chk("pclr_rd", rdata_q, 32'h00000000);
  endtask : t_w1c

  // Write-only command strobe and a read-only register that ignores writes.
  task automatic t_wo_ro();
    acc(1'b0, 1'b1, rfa_pkg::IDX_CMD, 32'h12345678);
    chk("cmd", cmd_q, 32'h12345678);
    chk("cmd_stb", {31'h0, cmd_stb_q}, 32'h00000001);
    @(posedge clk);
    hw_ro <= 8'h3c;
    #1;
    chk("cmd_stb0", {31'h0, cmd_stb_q}, 32'h00000000);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, idx: rfa_pkg::IDX_INFO, wdata: 32'h00000000};
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, idx: rfa_pkg::IDX_INFO, wdata: 32'h00000000};
    @(posedge clk);
    req <= '0;
    #1;
    chk("info", rdata_q, 32'h0000f03c);
  endtask : t_wo_ro

  // A reset in mid-run brings the ctrl, stat, pend and cmd fields back.
  task automatic t_rereset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("ctrl_lo", {24'h000000, ctrl_lo}, 32'h00000001);
    chk("ctrl_hi", {15'h0000, ctrl_hi}, 32'h00000000);
    chk("stat", {16'h0000, stat}, 32'h00000000);
    chk("pend", {24'h000000, pend}, 32'h00000000);
    chk("cmd", cmd_q, 32'h00000000);
    acc(1'b1, 1'b0, rfa_pkg::IDX_CTRL, 32'h00000000);
    chk("ctrl_rd", rdata_q, 32'h00000001);
  endtask : t_rereset

  // Main sequence.
  initial begin
    rst = 1'b1;
    req = '0;
    hw_evt = '0;
    hw_stat = '0;
    hw_pend = '0;
    hw_ro = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rc();
    t_ctrl();
    t_w1c();
    t_wo_ro();
    t_rereset();
    results();
  end

  // Bound on the whole run.
  initial begin
    repeat (10000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule : rfa_reg_bank_tb
`default_nettype wire
